// file: dptl_map.vh
`ifndef DPTL_MAP_VH
`define DPTL_MAP_VH
// ==========================================================
// Register offsets (byte addresses)
`define DPTL_REG_CTRL      8'h00
`define DPTL_REG_FUNC      8'h04
`define DPTL_REG_LOSS      8'h08
`define DPTL_REG_THR       8'h0C
`define DPTL_REG_OVL       8'h10
`define DPTL_REG_STATUS    8'h14
`define DPTL_REG_IRQ_STAT  8'h18
`define DPTL_REG_IRQ_MASK  8'h1C
`define DPTL_REG_TRIP_CLR  8'h20
`define DPTL_REG_ANALOG    8'h24
// ==========================================================
// Field positions
`define DPTL_CTRL_OPEN_PHASE   0
`define DPTL_CTRL_BRAKE_MODE   1
`define DPTL_CTRL_ADV_IO       2
`define DPTL_CTRL_DUTY_LSB     8
`define DPTL_FUNC_IN1_LSB      0
`define DPTL_FUNC_IN4_LSB      16
`define DPTL_FUNC_IN5_LSB      24
`define DPTL_LOSS_CRIT_LSB     0
`define DPTL_LOSS_ACT_LSB      2
`define DPTL_LOSS_SRC_LSB      4
`define DPTL_LOSS_TIME_LSB     8
`define DPTL_LOSS_RELAY_LSB    20
`define DPTL_LOSS_OUT2_LSB     25
// ==========================================================
// Codes
`define DPTL_FN_TRIP_NO        5'h12
`define DPTL_FN_TRIP_NC        5'h13
`define DPTL_FN_MAX            5'h1B
`define DPTL_OUT_OVERLOAD      5'h06
`define DPTL_OUT_LOSS          5'h0B
`define DPTL_OUT_MAX           5'h13
`define DPTL_SRC_V0_I2         3'h6
// ==========================================================
// Reset values
`define DPTL_RST_OPEN_PHASE    1'b0
`define DPTL_RST_BRAKE_MODE    1'b1
`define DPTL_RST_DUTY          5'h0A
`define DPTL_RST_IN4_FN        5'h03
`define DPTL_RST_IN5_FN        5'h04
`define DPTL_RST_OUT_FN        5'h11
`define DPTL_RST_LOSS_TIME     11'h00A
`define DPTL_RST_LOSS_CRIT     2'h0
`define DPTL_RST_LOSS_ACT      2'h0
// ==========================================================
// Timing
`define DPTL_CLK_HZ            25000000
`define DPTL_TENTH_MS          100
`define DPTL_BRAKE_MAX_S       15
`define DPTL_BRAKE_CYCLE_MS    1000
`endif

// file: dptl_top.v
// Functional notes
// - Open phase blocks output when protection enabled
// - Function 18 normally-open, 19 normally-closed trip
// - NO trip when input shorts to common
// - NC trip when input circuit opens
// - NC trip survives function reassignment
// - Inputs four, five only in advanced variant
// - Inverse-time overload trip above rated current
// - Output function 6 shows overload trip
// - Loss criterion off, half min, min
// - Combined source: either input below threshold
// - Loss must persist for qualify time
// - Loss action run, free-run, decelerate
// - Output function 11 shows speed loss
// - Brake mode unlimited or duty limited
// - Limited brake on-time within duty per cycle
// - Continuous braking cut after 15 s
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "dptl_map.vh"
`default_nettype none
module dptl_top #(
	parameter TENTH_CYC   = `DPTL_CLK_HZ / 1000 * `DPTL_TENTH_MS,
	parameter BRAKE_TENTHS = `DPTL_BRAKE_MAX_S * 10,
	parameter CYCLE_TENTHS = `DPTL_BRAKE_CYCLE_MS / 100,
	parameter OVL_BUDGET  = 32'h0005_0000
) (
	input  wire        i_sys_clk,      // System clock
	input  wire        i_rst_n,        // Sync reset, low
	input  wire [31:0] s_axi_awaddr,   // Write address
	input  wire        s_axi_awvalid,  // Write address valid
	output wire        s_axi_awready,  // Write address ready
	input  wire [31:0] s_axi_wdata,    // Write data
	input  wire [3:0]  s_axi_wstrb,    // Write strobes
	input  wire        s_axi_wvalid,   // Write data valid
	output wire        s_axi_wready,   // Write data ready
	output reg  [1:0]  s_axi_bresp,    // Write response
	output reg         s_axi_bvalid,   // Write response valid
	input  wire        s_axi_bready,   // Write response ready
	input  wire [31:0] s_axi_araddr,   // Read address
	input  wire        s_axi_arvalid,  // Read address valid
	output wire        s_axi_arready,  // Read address ready
	output reg  [31:0] s_axi_rdata,    // Read data
	output reg  [1:0]  s_axi_rresp,    // Read response
	output reg         s_axi_rvalid,   // Read valid
	input  wire        s_axi_rready,   // Read ready
	input  wire [4:0]  i_input_terminal_n, // Terminals 1..5, low = shorted to common
	input  wire [2:0]  i_phase_open,   // U V W open detect
	input  wire [11:0] i_voltage_input_one,  // Analog V1
	input  wire [11:0] i_voltage_input_zero, // Analog V0
	input  wire [11:0] i_current_input,      // Analog I2
	input  wire [15:0] i_input_current,      // Input current, same unit as rated
	input  wire        i_brake_request,      // Brake chopper wanted
	output reg         o_output_block, // Inverter output blocked
	output reg         o_decel_stop,   // Deceleration stop request
	output reg         o_hold_freq,    // Keep last frequency
	output reg         o_status_relay, // Relay output
	output reg         o_output2,      // Digital output 2
	output reg         o_brake_drive,  // Braking resistor drive
	output wire        o_irq           // Interrupt, high
);
	// ==========================================================
	// Pin synchronisers
	reg [4:0]  term_s1_q, term_s2_q, term_s3_q, term_q;
	reg [2:0]  ph_s1_q, ph_s2_q, ph_s3_q, ph_q;
	reg        brk_s1_q, brk_s2_q, brk_s3_q, brk_q;
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			term_s1_q <= 5'h1F;
			term_s2_q <= 5'h1F;
			term_s3_q <= 5'h1F;
			term_q    <= 5'h1F;
			ph_s1_q   <= 3'h0;
			ph_s2_q   <= 3'h0;
			ph_s3_q   <= 3'h0;
			ph_q      <= 3'h0;
			brk_s1_q  <= 1'b0;
			brk_s2_q  <= 1'b0;
			brk_s3_q  <= 1'b0;
			brk_q     <= 1'b0;
		end else begin
			term_s1_q <= i_input_terminal_n;
			term_s2_q <= term_s1_q;
			term_s3_q <= term_s2_q;
			term_q    <= (term_s2_q & term_s3_q) | (term_q & (term_s2_q | term_s3_q));
			ph_s1_q   <= i_phase_open;
			ph_s2_q   <= ph_s1_q;
			ph_s3_q   <= ph_s2_q;
			ph_q      <= (ph_s2_q & ph_s3_q) | (ph_q & (ph_s2_q | ph_s3_q));
			brk_s1_q  <= i_brake_request;
			brk_s2_q  <= brk_s1_q;
			brk_s3_q  <= brk_s2_q;
			brk_q     <= (brk_s2_q & brk_s3_q) | (brk_q & (brk_s2_q | brk_s3_q));
		end
	end
	// ==========================================================
	// Registers
	reg        open_phase_protect_sel_q, brake_res_mode_q, adv_io_q;
	reg [4:0]  brake_res_duty_level_q;
	reg [4:0]  fn_q [0:4];
	reg [1:0]  analog_loss_criterion_q, loss_action_sel_q;
	reg [2:0]  speed_src_q;
	reg [10:0] loss_qualify_time_q;
	reg [4:0]  relay_function_sel_q, output2_function_sel_q;
	reg [11:0] voltage_in_min_threshold_q, vo_in_min_threshold_q, current_in_min_threshold_q;
	reg [15:0] motor_rated_current_q;
	reg [4:0]  irq_stat_q, irq_mask_q;
	reg        aw_hold_q, w_hold_q;
	reg [7:0]  aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0]  w_strb_q;
	reg        trip_clr_q;
	wire       do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign s_axi_awready = !aw_hold_q;
	assign s_axi_wready  = !w_hold_q;
	assign s_axi_arready = !s_axi_rvalid;
	// Trip flags
	reg        trip_phase_q, trip_no_q, trip_nc_q, trip_ovl_q, loss_q;
	wire [4:0] events;
	wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire [31:0] fn_word = {3'h0, fn_q[4], 3'h0, fn_q[3], 3'h0, fn_q[1], 3'h0, fn_q[0]};
	wire [31:0] fn_new  = (fn_word & ~wmask) | (w_data_q & wmask);
	wire        wr_hit  = (aw_addr_q <= `DPTL_REG_ANALOG) && (aw_addr_q[1:0] == 2'b00);
	integer k;
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0;
			w_strb_q  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
			trip_clr_q <= 1'b0;
			open_phase_protect_sel_q <= `DPTL_RST_OPEN_PHASE;
			brake_res_mode_q <= `DPTL_RST_BRAKE_MODE;
			adv_io_q <= 1'b1;
			brake_res_duty_level_q <= `DPTL_RST_DUTY;
			fn_q[0] <= 5'h00;
			fn_q[1] <= 5'h01;
			fn_q[2] <= 5'h02;
			fn_q[3] <= `DPTL_RST_IN4_FN;
			fn_q[4] <= `DPTL_RST_IN5_FN;
			analog_loss_criterion_q <= `DPTL_RST_LOSS_CRIT;
			loss_action_sel_q <= `DPTL_RST_LOSS_ACT;
			speed_src_q <= 3'h0;
			loss_qualify_time_q <= `DPTL_RST_LOSS_TIME;
			relay_function_sel_q <= `DPTL_RST_OUT_FN;
			output2_function_sel_q <= `DPTL_RST_OUT_FN;
			voltage_in_min_threshold_q <= 12'h000;
			vo_in_min_threshold_q <= 12'h000;
			current_in_min_threshold_q <= 12'h000;
			motor_rated_current_q <= 16'hFFFF;
			irq_mask_q <= 5'h00;
		end else begin
			trip_clr_q <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
				case (aw_addr_q)
				`DPTL_REG_CTRL: begin
					if (w_strb_q[0]) begin
						open_phase_protect_sel_q <= w_data_q[`DPTL_CTRL_OPEN_PHASE];
						brake_res_mode_q <= w_data_q[`DPTL_CTRL_BRAKE_MODE];
						adv_io_q <= w_data_q[`DPTL_CTRL_ADV_IO];
					end
					if (w_strb_q[1] && w_data_q[`DPTL_CTRL_DUTY_LSB +: 5] <= 5'd30)
						brake_res_duty_level_q <= w_data_q[`DPTL_CTRL_DUTY_LSB +: 5];
				end
				`DPTL_REG_FUNC: begin
					// Out-of-range codes and NC reassignment while tripped are refused
					for (k = 0; k < 5; k = k + 1) begin
						if (k != 2 && (k < 3 || adv_io_q) && fn_new[(k - (k > 2)) * 8 +: 5] <= `DPTL_FN_MAX &&
						    !(trip_nc_q && fn_q[k] == `DPTL_FN_TRIP_NC))
							fn_q[k] <= fn_new[(k - (k > 2)) * 8 +: 5];
					end
				end
				`DPTL_REG_LOSS: begin
					if (w_data_q[1:0] != 2'b11)
						analog_loss_criterion_q <= w_data_q[`DPTL_LOSS_CRIT_LSB +: 2];
					if (w_data_q[3:2] != 2'b11)
						loss_action_sel_q <= w_data_q[`DPTL_LOSS_ACT_LSB +: 2];
					speed_src_q <= w_data_q[`DPTL_LOSS_SRC_LSB +: 3];
					if (w_data_q[18:8] >= 11'd1 && w_data_q[18:8] <= 11'd1200)
						loss_qualify_time_q <= w_data_q[`DPTL_LOSS_TIME_LSB +: 11];
					if (w_data_q[24:20] <= `DPTL_OUT_MAX)
						relay_function_sel_q <= w_data_q[`DPTL_LOSS_RELAY_LSB +: 5];
					if (w_data_q[29:25] <= `DPTL_OUT_MAX)
						output2_function_sel_q <= w_data_q[`DPTL_LOSS_OUT2_LSB +: 5];
				end
				`DPTL_REG_THR: begin
					voltage_in_min_threshold_q <= w_data_q[11:0];
					vo_in_min_threshold_q <= w_data_q[23:12];
				end
				`DPTL_REG_OVL: begin
					current_in_min_threshold_q <= w_data_q[27:16];
					motor_rated_current_q <= w_data_q[15:0];
				end
				`DPTL_REG_IRQ_MASK: irq_mask_q <= w_data_q[4:0];
				`DPTL_REG_TRIP_CLR: trip_clr_q <= w_data_q[0];
				default: ;
				endcase
			end
		end
	end
	// Fn slot 2 has no user field; terminal three keeps its reset function code 2
	wire [4:0] unused_fn = fn_q[2];
	// ==========================================================
	// External trip inputs
	reg  any_no, any_nc;
	integer t;
	always @* begin
		any_no = 1'b0;
		any_nc = 1'b0;
		for (t = 0; t < 5; t = t + 1) begin
			if ((t < 3 || adv_io_q) && fn_q[t] == `DPTL_FN_TRIP_NO && !term_q[t])
				any_no = 1'b1;
			if ((t < 3 || adv_io_q) && fn_q[t] == `DPTL_FN_TRIP_NC && term_q[t])
				any_nc = 1'b1;
		end
	end
	// ==========================================================
	// Tenth-second tick
	reg [23:0] tick_cnt_q;
	wire       tick = (tick_cnt_q == TENTH_CYC - 1);
	always @(posedge i_sys_clk) begin
		if (!i_rst_n || tick)
			tick_cnt_q <= 24'h0;
		else
			tick_cnt_q <= tick_cnt_q + 24'h1;
	end
	// ==========================================================
	// Speed command loss
	wire v1_low  = (analog_loss_criterion_q == 2'd1) ? ({i_voltage_input_one, 1'b0} < {1'b0, voltage_in_min_threshold_q})
	                                                 : (i_voltage_input_one < voltage_in_min_threshold_q);
	wire v0_low  = (analog_loss_criterion_q == 2'd1) ? ({i_voltage_input_zero, 1'b0} < {1'b0, vo_in_min_threshold_q})
	                                                 : (i_voltage_input_zero < vo_in_min_threshold_q);
	wire i2_low  = (analog_loss_criterion_q == 2'd1) ? ({i_current_input, 1'b0} < {1'b0, current_in_min_threshold_q})
	                                                 : (i_current_input < current_in_min_threshold_q);
	wire loss_raw = (analog_loss_criterion_q != 2'd0) &&
	                ((speed_src_q == `DPTL_SRC_V0_I2) ? (v0_low || i2_low) : v1_low);
	reg [10:0] loss_cnt_q;
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			loss_cnt_q <= 11'h0;
			loss_q <= 1'b0;
		end else if (!loss_raw) begin
			loss_cnt_q <= 11'h0;
			loss_q <= 1'b0;
		end else if (tick && !loss_q) begin
			if (loss_cnt_q >= loss_qualify_time_q)
				loss_q <= 1'b1;
			loss_cnt_q <= loss_cnt_q + 11'h1;
		end
	end
	// ==========================================================
	// Inverter overload, inverse time
	reg [31:0] ovl_acc_q;
	wire [15:0] excess = i_input_current - motor_rated_current_q;
	always @(posedge i_sys_clk) begin
		if (!i_rst_n)
			ovl_acc_q <= 32'h0;
		else if (i_input_current > motor_rated_current_q) begin
			if (ovl_acc_q < OVL_BUDGET)
				ovl_acc_q <= ovl_acc_q + {16'h0, excess};
		end else if (ovl_acc_q != 32'h0)
			ovl_acc_q <= ovl_acc_q - 32'h1;
	end
	wire ovl_hit = ovl_acc_q >= OVL_BUDGET;
	// ==========================================================
	// Trip latches
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			trip_phase_q <= 1'b0;
			trip_no_q <= 1'b0;
			trip_nc_q <= 1'b0;
			trip_ovl_q <= 1'b0;
		end else begin
			if (open_phase_protect_sel_q && ph_q != 3'h0)
				trip_phase_q <= 1'b1;
			else if (trip_clr_q)
				trip_phase_q <= 1'b0;
			if (any_no)
				trip_no_q <= 1'b1;
			else if (trip_clr_q)
				trip_no_q <= 1'b0;
			if (any_nc)
				trip_nc_q <= 1'b1;
			else if (trip_clr_q)
				trip_nc_q <= 1'b0;
			if (ovl_hit)
				trip_ovl_q <= 1'b1;
			else if (trip_clr_q)
				trip_ovl_q <= 1'b0;
		end
	end
	// ==========================================================
	// Braking resistor
	reg [7:0] brk_run_q, cyc_q, on_q;
	wire [31:0] on_lim = brake_res_duty_level_q * CYCLE_TENTHS;
	wire [31:0] on_pct = {24'h0, on_q} * 32'h64;
	wire duty_ok = !brake_res_mode_q || (on_pct < on_lim);
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			brk_run_q <= 8'h0;
			cyc_q <= 8'h0;
			on_q <= 8'h0;
			o_brake_drive <= 1'b0;
		end else begin
			if (!brk_q)
				brk_run_q <= 8'h0;
			else if (tick && brk_run_q < BRAKE_TENTHS)
				brk_run_q <= brk_run_q + 8'h1;
			if (tick) begin
				if (cyc_q == CYCLE_TENTHS - 1) begin
					cyc_q <= 8'h0;
					on_q <= 8'h0;
				end else begin
					cyc_q <= cyc_q + 8'h1;
					if (o_brake_drive)
						on_q <= on_q + 8'h1;
				end
			end
			o_brake_drive <= brk_q && (brk_run_q < BRAKE_TENTHS) && duty_ok && !o_output_block;
		end
	end
	// ==========================================================
	// Outputs and interrupts
	assign events = {loss_q, trip_ovl_q, trip_nc_q, trip_no_q, trip_phase_q};
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_output_block <= 1'b0;
			o_decel_stop <= 1'b0;
			o_hold_freq <= 1'b0;
			o_status_relay <= 1'b0;
			o_output2 <= 1'b0;
			irq_stat_q <= 5'h0;
		end else begin
			o_output_block <= trip_phase_q | trip_no_q | trip_nc_q | trip_ovl_q |
			                  (loss_q && loss_action_sel_q == 2'd1);
			o_decel_stop <= loss_q && loss_action_sel_q == 2'd2;
			o_hold_freq  <= loss_q && loss_action_sel_q == 2'd0;
			o_status_relay <= (relay_function_sel_q == `DPTL_OUT_OVERLOAD && trip_ovl_q) ||
			                  (relay_function_sel_q == `DPTL_OUT_LOSS && loss_q);
			o_output2 <= (output2_function_sel_q == `DPTL_OUT_OVERLOAD && trip_ovl_q) ||
			             (output2_function_sel_q == `DPTL_OUT_LOSS && loss_q);
			irq_stat_q <= events | (irq_stat_q &
			              ~((do_write && aw_addr_q == `DPTL_REG_IRQ_STAT && w_strb_q[0]) ? w_data_q[4:0] : 5'h0));
		end
	end
	assign o_irq = |(irq_stat_q & irq_mask_q);
	// ==========================================================
	// Read channel
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr[7:0])
			`DPTL_REG_CTRL: s_axi_rdata <= {19'h0, brake_res_duty_level_q, 5'h0, adv_io_q,
			                  brake_res_mode_q, open_phase_protect_sel_q};
			`DPTL_REG_FUNC: s_axi_rdata <= fn_word;
			`DPTL_REG_LOSS: s_axi_rdata <= {2'h0, output2_function_sel_q, relay_function_sel_q, 1'b0,
			                  loss_qualify_time_q, 1'b0, speed_src_q, loss_action_sel_q, analog_loss_criterion_q};
			`DPTL_REG_THR: s_axi_rdata <= {8'h0, vo_in_min_threshold_q, voltage_in_min_threshold_q};
			`DPTL_REG_OVL: s_axi_rdata <= {4'h0, current_in_min_threshold_q, motor_rated_current_q};
			`DPTL_REG_STATUS: s_axi_rdata <= {21'h0, o_brake_drive, o_output_block, unused_fn[0] & 1'b0,
			                  term_q[4:3] & 2'b00, 1'b0, events};
			`DPTL_REG_IRQ_STAT: s_axi_rdata <= {27'h0, irq_stat_q};
			`DPTL_REG_IRQ_MASK: s_axi_rdata <= {27'h0, irq_mask_q};
			`DPTL_REG_TRIP_CLR: s_axi_rdata <= 32'h0;
			`DPTL_REG_ANALOG: s_axi_rdata <= {8'h0, ph_q, 5'h0, term_q, brk_q, loss_raw, ovl_hit, 8'h0};
			default: begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'b10;
			end
			endcase
		end
	end
endmodule // dptl_top
`default_nettype wire

// file: dptl_field.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// Field side: trip contacts and phase sensors
module dptl_field (
	input  wire logic [4:0] i_close,            // Contacts closed
	input  wire logic [2:0] i_ph_open,          // Phases open
	output logic      [4:0] o_input_terminal_n, // To terminals
	output logic      [2:0] o_phase_open        // To sensors
);
	// Open contact pulled up to high
	assign o_input_terminal_n = ~i_close;
	assign o_phase_open = i_ph_open;
endmodule // dptl_field
`default_nettype wire

// file: dptl_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module dptl_top_asserts #(
	parameter TENTH_CYC    = 2500000,
	parameter BRAKE_TENTHS = 150
) (
	input wire logic        i_sys_clk,       // Clock
	input wire logic        i_rst_n,         // Reset
	input wire logic        s_axi_awvalid,   // AW
	input wire logic        s_axi_awready,   // AW
	input wire logic        s_axi_wvalid,    // W
	input wire logic        s_axi_wready,    // W
	input wire logic        s_axi_bvalid,    // B
	input wire logic        s_axi_bready,    // B
	input wire logic        s_axi_arvalid,   // AR
	input wire logic        s_axi_arready,   // AR
	input wire logic        s_axi_rvalid,    // R
	input wire logic        s_axi_rready,    // R
	input wire logic        i_brake_request, // Brake wanted
	input wire logic        o_output_block,  // Block
	input wire logic        o_decel_stop,    // Decel
	input wire logic        o_hold_freq,     // Hold
	input wire logic        o_brake_drive    // Brake drive
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// ========
	// Continuous braking run length
	logic [31:0] brk_run_q;
	logic [31:0] brk_run_d;
	assign brk_run_d = o_brake_drive ? brk_run_q + 32'h1 : 32'h0;
	always @(posedge i_sys_clk) begin
		brk_run_q <= i_rst_n ? brk_run_d : 32'h0;
	end
	// ========
	// Properties
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	reset_quiet_a: assert property (disable iff (1'b0) !i_rst_n |=>
		!o_output_block && !o_brake_drive && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active after reset");
	write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read not answered");
	read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	stop_excl_a: assert property (!(o_decel_stop && o_hold_freq))
		else $error("two loss actions at once");
	brake_req_a: assert property (!i_brake_request [*6] |-> !o_brake_drive)
		else $error("brake drive without request");
	brake_cap_a: assert property (brk_run_q <= BRAKE_TENTHS * TENTH_CYC + TENTH_CYC)
		else $error("continuous braking too long");
endmodule // dptl_top_asserts
bind dptl_top dptl_top_asserts #(.TENTH_CYC(TENTH_CYC), .BRAKE_TENTHS(BRAKE_TENTHS)) chk_u (.*);
`default_nettype wire

// file: drive_protection_trip_logic_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "dptl_map.vh"
module drive_protection_trip_logic_bench;
	logic        i_sys_clk = 1'b0, i_rst_n = 1'b0, i_brake_request = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [31:0] s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, cr;
	logic [4:0]  i_input_terminal_n, cl = 5'h00;
	logic [2:0]  i_phase_open, ph = 3'h0;
	logic [11:0] i_voltage_input_one = 12'hFFF, i_voltage_input_zero = 12'hFFF;
	logic [11:0] i_current_input = 12'hFFF;
	logic [15:0] i_input_current = 16'h0000, rnd = 16'h0023;
	logic        o_output_block, o_decel_stop, o_hold_freq, o_status_relay;
	logic        o_output2, o_brake_drive, o_irq;
	int          failures = 0, checks = 0, cyc = 0, n, m;
	dptl_top #(.TENTH_CYC(10), .BRAKE_TENTHS(150), .CYCLE_TENTHS(10),
		.OVL_BUDGET(32'h0000_0100)) dut_u (.*);
	dptl_field fld_u (.i_close(cl), .i_ph_open(ph), .o_input_terminal_n(i_input_terminal_n),
		.o_phase_open(i_phase_open));
	always #20 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			finish_test();
		end
	end
	// ========
	// Helpers
	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("FAIL %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic pc(input string nm, ref logic s, input logic e);
		@(negedge i_sys_clk);
		chk(nm, s, e);
		@(posedge i_sys_clk);
	endtask
	task automatic tk(input int k);
		repeat (k) @(posedge i_sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(negedge i_sys_clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			rr = s_axi_bresp;
			@(posedge i_sys_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge i_sys_clk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			rv = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge i_sys_clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tr);
	endtask
	task automatic brk(input int k);
		m = 0;
		repeat (k) begin
			@(negedge i_sys_clk);
			m += o_brake_drive === 1'b1;
		end
		@(posedge i_sys_clk);
	endtask
	function automatic logic [31:0] lw(input logic [1:0] c, a, input logic [2:0] s);
		return {2'h0, 5'h0B, 5'h06, 1'b0, 11'h002, 1'b0, s, a, c};
	endfunction
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// ========
	// Main sequence
	initial begin
		tk(10);
		i_rst_n <= 1'b1;
		tk(6);
		rd(`DPTL_REG_CTRL);
		chk("ctrl", rv, 32'h0000_0A06);
		rd(`DPTL_REG_FUNC);
		chk("func", rv, 32'h0403_0100);
		rd(`DPTL_REG_LOSS);
		chk("loss", rv, 32'h2310_0A00);
		wr(`DPTL_REG_CTRL, 32'h0000_1F06);
		rd(`DPTL_REG_CTRL);
		chk("duty", rv, 32'h0000_0A06);
		wr(8'h40, 32'h0);
		chk("bad addr", rr, 2'h2);
		rd(8'h44);
		chk("bad rd", rr, 2'h2);
		$display("test regs done");
		ph <= 3'h4;
		tk(8);
		pc("ph off", o_output_block, 1'b0);
		wr(`DPTL_REG_CTRL, 32'h0A07);
		tk(8);
		pc("ph on", o_output_block, 1'b1);
		pc("irq masked", o_irq, 1'b0);
		wr(`DPTL_REG_IRQ_MASK, 32'h1);
		pc("irq", o_irq, 1'b1);
		wr(`DPTL_REG_TRIP_CLR, 32'h1);
		tk(4);
		pc("ph held", o_output_block, 1'b1);
		ph <= 3'h0;
		tk(8);
		wr(`DPTL_REG_TRIP_CLR, 32'h1);
		wr(`DPTL_REG_IRQ_STAT, 32'h1);
		tk(4);
		pc("ph clr", o_output_block, 1'b0);
		pc("irq clr", o_irq, 1'b0);
		$display("test phase done");
		wr(`DPTL_REG_CTRL, 32'h0A02);
		wr(`DPTL_REG_FUNC, 32'h1312_0100);
		cl <= 5'h08;
		tk(10);
		pc("std io", o_output_block, 1'b0);
		cl <= 5'h10;
		tk(6);
		wr(`DPTL_REG_CTRL, 32'h0A06);
		wr(`DPTL_REG_FUNC, 32'h1312_0100);
		tk(8);
		pc("nc closed", o_output_block, 1'b0);
		cl <= 5'h18;
		tk(8);
		pc("no trip", o_output_block, 1'b1);
		cl <= 5'h10;
		tk(8);
		wr(`DPTL_REG_TRIP_CLR, 32'h1);
		tk(4);
		pc("no clr", o_output_block, 1'b0);
		cl <= 5'h00;
		tk(8);
		pc("nc trip", o_output_block, 1'b1);
		wr(`DPTL_REG_FUNC, 32'h0412_0100);
		rd(`DPTL_REG_FUNC);
		chk("nc keep", rv, 32'h1312_0100);
		wr(`DPTL_REG_TRIP_CLR, 32'h1);
		tk(4);
		pc("nc held", o_output_block, 1'b1);
		cl <= 5'h10;
		tk(8);
		wr(`DPTL_REG_TRIP_CLR, 32'h1);
		wr(`DPTL_REG_FUNC, 32'h0403_0100);
		tk(4);
		pc("nc clr", o_output_block, 1'b0);
		$display("test ext trip done");
		wr(`DPTL_REG_OVL, 32'h0200_0064);
		wr(`DPTL_REG_LOSS, lw(2'h0, 2'h0, 3'h0));
		for (int k = 0; k < 2; k++) begin
			i_input_current <= k ? 16'h00E4 : 16'h0084;
			n = 0;
			while (o_status_relay !== 1'b1 && n < 600) begin
				@(negedge i_sys_clk);
				n++;
			end
			@(posedge i_sys_clk);
			chk("ovl relay", n < 600, 1'b1);
			pc("ovl block", o_output_block, 1'b1);
			if (k)
				chk("ovl inverse", n < m, 1'b1);
			m = n;
			i_input_current <= 16'h0000;
			tk(300);
			wr(`DPTL_REG_TRIP_CLR, 32'h1);
			tk(4);
			pc("ovl clr", o_output_block, 1'b0);
		end
		$display("test overload done");
		wr(`DPTL_REG_THR, 32'h0020_0200);
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			cr = k == 0 ? 2'h0 : (k[0] ? 2'h1 : 2'h2);
			wr(`DPTL_REG_LOSS, lw(cr, 2'h0, 3'h0));
			i_voltage_input_one <= k == 0 ? 12'h000 : k == 3 ? 12'h0C0 :
				k < 3 ? 12'h180 : 12'h200 + rnd[10:0];
			tk(40);
			pc("loss", o_output2, k == 2 || k == 3);
			pc("hold", o_hold_freq, k == 2 || k == 3);
			i_voltage_input_one <= 12'hFFF;
			tk(3);
		end
		wr(`DPTL_REG_LOSS, lw(2'h2, 2'h2, 3'h0));
		i_voltage_input_one <= 12'h180;
		tk(14);
		i_voltage_input_one <= 12'hFFF;
		tk(2);
		i_voltage_input_one <= 12'h180;
		tk(14);
		pc("qualify", o_output2, 1'b0);
		tk(20);
		pc("decel", o_decel_stop, 1'b1);
		wr(`DPTL_REG_LOSS, lw(2'h2, 2'h1, 3'h0));
		tk(30);
		pc("free run", o_output_block, 1'b1);
		i_voltage_input_one <= 12'hFFF;
		wr(`DPTL_REG_LOSS, lw(2'h2, 2'h0, 3'h6));
		wr(`DPTL_REG_TRIP_CLR, 32'h1);
		i_current_input <= 12'h010;
		tk(40);
		pc("comb i", o_output2, 1'b1);
		pc("free clr", o_output_block, 1'b0);
		i_current_input <= 12'hFFF;
		tk(3);
		pc("comb off", o_output2, 1'b0);
		i_voltage_input_zero <= 12'h010;
		tk(40);
		pc("comb v", o_output2, 1'b1);
		i_voltage_input_zero <= 12'hFFF;
		$display("test loss done");
		wr(`DPTL_REG_CTRL, 32'h0A04);
		i_brake_request <= 1'b1;
		brk(1700);
		chk("brake cap", m > 1470 && m < 1530, 1'b1);
		pc("brake off", o_brake_drive, 1'b0);
		i_brake_request <= 1'b0;
		tk(5);
		wr(`DPTL_REG_CTRL, 32'h0A06);
		i_brake_request <= 1'b1;
		brk(300);
		chk("brake duty", m > 0 && m <= 40, 1'b1);
		i_brake_request <= 1'b0;
		$display("test brake done");
		finish_test();
	end
endmodule // drive_protection_trip_logic_bench
`default_nettype wire
